// file: blc_defs.svh
// register map, field positions, reset values and counts of the black-level unit
`ifndef BLC_DEFS_SVH
`define BLC_DEFS_SVH

`define BLC_IDX_CALCFG  10'h080
`define BLC_IDX_CTRL    10'h081
`define BLC_IDX_FAULT   10'h088
`define BLC_IDX_DARKROW 10'h0C5
`define BLC_IDX_IRQSTS  10'h0F0
`define BLC_IDX_IRQMSK  10'h0F1

`define BLC_AUTO_BIT    0
`define BLC_OFS_LSB     1
`define BLC_OFS_MSB     9
`define BLC_DEC_BIT     10
`define BLC_ROWS_LSB    0
`define BLC_ROWS_MSB    7
`define BLC_SKIP_LSB    8
`define BLC_SKIP_MSB    12
`define BLC_DEPTH_LSB   8
`define BLC_DEPTH_MSB   10

`define BLC_FREEZE_CODE 9'h1FF
`define BLC_CTRL_RST    16'h0001
`define BLC_DARKROW_RST 16'h0102
`define BLC_CALCFG_RST  16'h0300
`define BLC_KERNELS     7'd80
`define BLC_KCOLS       64

`define BLC_IRQ_DONE    0
`define BLC_IRQ_FAULT   1

`endif

// file: blc_pkg.sv
// types of the black-level unit
package blc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DARK, ST_IMAGE} blc_state_t;
  typedef logic signed [11:0] blc_ofs_t;
endpackage

// file: blc_top.sv
// black-level unit: dark line sequencing, calibration and offset compensation
`timescale 1ns/1ns
`include "blc_defs.svh"
module blc_top #(
  parameter int         NPATH  = 4,
  parameter int         PW     = 10,
  parameter logic [9:0] TARGET = 10'h020
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [11:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // pixel stream from column readout
  input  wire logic                  frameStart,
  input  wire logic                  lineStart,
  input  wire logic                  pixValid,
  input  wire logic [NPATH*PW-1:0]   pixData,
  // pixel stream out
  output logic                       darkGen,
  output logic                       pixOutValid,
  output logic                       pixOutDark,
  output logic      [NPATH*PW-1:0]   pixOutData,
  // status
  output logic      [NPATH-1:0]      darkCalFaultFlags,
  output logic                       irq
);
  import blc_pkg::*;

  localparam int AW = PW + 7;
  localparam int NC = `BLC_KCOLS;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] wmerge(
    input logic [15:0] oldV,
    input logic [15:0] newV,
    input logic [1:0]  sel
  );
    logic [15:0] r;
    r = oldV;
    if (sel[0]) begin
      r[7:0] = newV[7:0];
    end
    if (sel[1]) begin
      r[15:8] = newV[15:8];
    end
    return r;
  endfunction

  function automatic logic [PW-1:0] applyOfs(
    input logic [PW-1:0] pix,
    input blc_ofs_t      ofs
  );
    logic signed [12:0] v;
    v = $signed({3'b000, pix}) + $signed({ofs[11], ofs});
    if (v < 0) begin
      return '0;
    end else if (v > $signed({3'b000, {PW{1'b1}}})) begin
      return {PW{1'b1}};
    end else begin
      return v[PW-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [15:0]      ctrl_r;
  logic [15:0]      darkRow_r;
  logic [15:0]      calCfg_r;
  logic [1:0]       irqSts_r;
  logic [1:0]       irqMsk_r;
  logic [1:0]       irqEv;
  logic [9:0]       wIdx;
  logic             wbReq;
  logic             wr;

  assign wIdx  = wb_adr_i[11:2];
  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = wbReq & wb_we_i;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wbReq) begin
      case (wIdx)
        `BLC_IDX_CTRL:    wb_dat_o <= {16'h0000, ctrl_r};
        `BLC_IDX_DARKROW: wb_dat_o <= {16'h0000, darkRow_r};
        `BLC_IDX_CALCFG:  wb_dat_o <= {16'h0000, calCfg_r};
        `BLC_IDX_FAULT:   wb_dat_o <= 32'(darkCalFaultFlags);
        `BLC_IDX_IRQSTS:  wb_dat_o <= 32'(irqSts_r);
        `BLC_IDX_IRQMSK:  wb_dat_o <= 32'(irqMsk_r);
        default:          wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r    <= `BLC_CTRL_RST;
      darkRow_r <= `BLC_DARKROW_RST;
      calCfg_r  <= `BLC_CALCFG_RST;
      irqMsk_r  <= 2'b00;
    end else if (wr) begin
      case (wIdx)
        `BLC_IDX_CTRL: begin
          ctrl_r <= wmerge(ctrl_r, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        `BLC_IDX_DARKROW: begin
          darkRow_r <= wmerge(darkRow_r, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        `BLC_IDX_CALCFG: begin
          calCfg_r <= wmerge(calCfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        `BLC_IDX_IRQMSK: begin
          if (wb_sel_i[0]) begin
            irqMsk_r <= wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irqSts_r <= 2'b00;
    end else if (wr && wIdx == `BLC_IDX_IRQSTS && wb_sel_i[0]) begin
      irqSts_r <= (irqSts_r & ~wb_dat_i[1:0]) | irqEv;
    end else begin
      irqSts_r <= irqSts_r | irqEv;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqSts_r | irqEv) & irqMsk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control decode

  logic             autoEn;
  logic [8:0]       manOfs;
  logic             manDec;
  logic             freeze;
  logic [2:0]       depth;
  logic [7:0]       req;
  blc_ofs_t         manSigned;

  assign autoEn = ctrl_r[`BLC_AUTO_BIT];
  assign manOfs = ctrl_r[`BLC_OFS_MSB:`BLC_OFS_LSB];
  assign manDec = ctrl_r[`BLC_DEC_BIT];
  assign freeze = autoEn && manOfs == `BLC_FREEZE_CODE;
  assign depth  = calCfg_r[`BLC_DEPTH_MSB:`BLC_DEPTH_LSB];
  assign req    = 8'h01 << depth;
  assign manSigned = manDec ? 12'h000 - {3'b000, manOfs} : {3'b000, manOfs};

  ////////////////////////////////////////////////////////////////////////////
  // dark line sequencer

  blc_state_t       state_r;
  logic [7:0]       lines_r;
  logic [4:0]       skip_r;
  logic [7:0]       row_r;
  logic [6:0]       kern_r;
  logic [5:0]       col_r;
  logic [7:0]       taken_r;
  logic             inDark;
  logic             blank;
  logic             kernEnd;
  logic             lineEnd;
  logic             darkDone;
  logic             accEn;
  logic             calc_r;
  logic             short;

  assign inDark   = state_r == ST_DARK;
  assign blank    = inDark && {3'b000, skip_r} > row_r;
  assign kernEnd  = col_r == 6'(NC - NPATH);
  assign lineEnd  = kernEnd && kern_r == `BLC_KERNELS - 7'd1;
  assign darkDone = inDark && pixValid && lineEnd
                    && row_r == lines_r - 8'h01;
  assign accEn    = inDark && pixValid && !blank && taken_r < req;
  assign short    = taken_r < req;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      lines_r <= 8'h00;
      skip_r  <= 5'h00;
    end else if (frameStart) begin
      state_r <= ST_DARK;
      lines_r <= darkRow_r[`BLC_ROWS_MSB:`BLC_ROWS_LSB];
      skip_r  <= darkRow_r[`BLC_SKIP_MSB:`BLC_SKIP_LSB];
    end else begin
      case (state_r)
        ST_DARK: begin
          if (darkDone) begin
            state_r <= ST_IMAGE;
          end
        end
        ST_IMAGE: state_r <= ST_IMAGE;
        ST_IDLE:  state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameStart) begin
      row_r  <= 8'h00;
      kern_r <= 7'h00;
    end else if (inDark && pixValid && kernEnd) begin
      if (lineEnd) begin
        kern_r <= 7'h00;
        row_r  <= row_r + 8'h01;
      end else begin
        kern_r <= kern_r + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameStart || (lineStart && !inDark)) begin
      col_r <= 6'h00;
    end else if (pixValid) begin
      col_r <= col_r + 6'(NPATH);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameStart) begin
      taken_r <= 8'h00;
    end else if (accEn && kernEnd) begin
      taken_r <= taken_r + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      darkGen <= 1'b0;
    end else begin
      darkGen <= frameStart || (inDark && !darkDone);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-column accumulation and offset calculation

  logic [AW-1:0]    acc_r [NC];
  blc_ofs_t         calOfs_r [NC];
  logic [PW-1:0]    avg [NC];

  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameStart) begin
      for (int c = 0; c < NC; c++) begin
        acc_r[c] <= '0;
      end
    end else if (accEn) begin
      for (int i = 0; i < NPATH; i++) begin
        acc_r[6'(int'(col_r) + i)] <= acc_r[6'(int'(col_r) + i)]
          + {{(AW-PW){1'b0}}, pixData[i*PW +: PW]};
      end
    end
  end

  generate
    for (genvar c = 0; c < NC; c++) begin : gAvg
      logic [AW-1:0] sh;
      assign sh     = acc_r[c] >> depth;
      assign avg[c] = sh[PW-1:0];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      calc_r <= 1'b0;
    end else begin
      calc_r <= darkDone;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < NC; c++) begin
        calOfs_r[c] <= '0;
      end
    end else if (calc_r && autoEn && !freeze && !short) begin
      for (int c = 0; c < NC; c++) begin
        calOfs_r[c] <= $signed({2'b00, TARGET}) - $signed({2'b00, avg[c]});
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      darkCalFaultFlags <= '0;
    end else if (calc_r) begin
      darkCalFaultFlags <= {NPATH{short}};
    end
  end

  assign irqEv[`BLC_IRQ_DONE]  = calc_r;
  assign irqEv[`BLC_IRQ_FAULT] = calc_r && short;

  ////////////////////////////////////////////////////////////////////////////
  // compensation of regular pixels

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pixOutValid <= 1'b0;
      pixOutDark  <= 1'b0;
      pixOutData  <= '0;
    end else begin
      pixOutValid <= pixValid && !blank;
      pixOutDark  <= inDark;
      for (int i = 0; i < NPATH; i++) begin
        if (inDark) begin
          pixOutData[i*PW +: PW] <= pixData[i*PW +: PW];
        end else if (autoEn) begin
          pixOutData[i*PW +: PW] <= applyOfs(pixData[i*PW +: PW],
            calOfs_r[6'(int'(col_r) + i)]);
        end else begin
          pixOutData[i*PW +: PW] <= applyOfs(pixData[i*PW +: PW],
            manSigned);
        end
      end
    end
  end

endmodule

// file: blc_top_properties.sv
// port-level checks of the black-level unit
`timescale 1ns/1ns
module blc_top_chk #(
  parameter int NPATH = 4,
  parameter int PW    = 10
) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  // pixel stream and fault flags
  input wire logic                frameStart,
  input wire logic                pixValid,
  input wire logic [NPATH*PW-1:0] pixData,
  input wire logic                darkGen,
  input wire logic                pixOutValid,
  input wire logic                pixOutDark,
  input wire logic [NPATH*PW-1:0] pixOutData,
  input wire logic [NPATH-1:0]    darkCalFaultFlags
);
  localparam int KBEATS = 80 * 64 / NPATH;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [19:0] beatCnt_r;
  // dark beats since frame start
  always_ff @(posedge ref_clk) begin
    if (sys_rst || frameStart) beatCnt_r <= '0;
    else if (pixValid && darkGen) beatCnt_r <= beatCnt_r + 20'h00001;
  end
  dark_start_a: assert property (frameStart |=> darkGen)
    else $error("no dark lines after frame start");
  dark_count_a: assert property ($fell(darkGen) |->
    beatCnt_r != 0 && beatCnt_r % KBEATS == 0)
    else $error("dark phase not whole lines");
  skip_out_a: assert property (pixOutValid |-> $past(pixValid))
    else $error("output beat without input beat");
  dark_raw_a: assert property (pixOutValid && pixOutDark |->
    pixOutData == $past(pixData)) else $error("dark sample altered");
  dark_mark_a: assert property (pixOutDark |-> $past(darkGen))
    else $error("dark mark outside dark phase");
  image_mark_a: assert property (pixOutValid && !$past(darkGen)
    |-> !pixOutDark) else $error("image beat marked dark");
  fault_lanes_a: assert property (darkCalFaultFlags == '0
    || &darkCalFaultFlags) else $error("fault lanes differ");
  fault_time_a: assert property ($changed(darkCalFaultFlags) |->
    $past(darkGen, 2) && !$past(darkGen))
    else $error("fault flags changed mid frame");
endmodule
bind blc_top blc_top_chk #(.NPATH(NPATH), .PW(PW)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .frameStart(frameStart),
  .pixValid(pixValid), .pixData(pixData), .darkGen(darkGen),
  .pixOutValid(pixOutValid), .pixOutDark(pixOutDark),
  .pixOutData(pixOutData), .darkCalFaultFlags(darkCalFaultFlags));

// file: tb_black_level_calibration.sv
// self-checking testbench of the black-level unit
`timescale 1ns/1ns
`include "blc_defs.svh"
`define CHK(n,e,a) begin numChecks++; if ((a) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); nMismatch++; end end
module tb_black_level_calibration;
  localparam logic [9:0] TGT = 10'h020;
  logic        ref_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
  logic        fs = 0, ls = 0, pv = 0, nC = 0, nV, nD, pC = 0, pV, pD;
  logic [11:0] adr = 0;
  logic [31:0] wdat = 0, wb_dat_o, q;
  logic [39:0] pd = 0, pixOutData, nDat, pDat;
  logic        wb_ack_o, darkGen, pixOutValid, pixOutDark, irq;
  logic [3:0]  darkCalFaultFlags;
  logic [15:0] ctrlV = 16'h0001;
  integer      seed = 32'h11F8;
  int          nMismatch = 0, numChecks = 0, cycles = 0;
  int          ofs[64] = '{default: 0};
  blc_top #(.NPATH(4), .PW(10), .TARGET(TGT)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frameStart(fs),
    .lineStart(ls), .pixValid(pv), .pixData(pd), .darkGen(darkGen),
    .pixOutValid(pixOutValid), .pixOutDark(pixOutDark),
    .pixOutData(pixOutData), .darkCalFaultFlags(darkCalFaultFlags),
    .irq(irq));
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [9:0] dv(int c, int k);
    return 10'(c * 3 + k);
  endfunction
  function automatic logic [9:0] comp(logic [9:0] p, int c);
    int v;
    v = ctrlV[0] ? int'(p) + ofs[c] : ctrlV[10] ? int'(p) - int'(ctrlV[9:1])
      : int'(p) + int'(ctrlV[9:1]);
    return v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : 10'(v);
  endfunction
  task automatic close_out;
    if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(logic w, logic [9:0] i, logic [15:0] d);
    @(posedge ref_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; wdat <= {16'h0000, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic chkReg(string n, logic [9:0] i, logic [31:0] e);
    wb(0, i, 16'h0000);
    `CHK(n, e, q)
  endtask
  task automatic beat(logic [39:0] d, logic v, logic k, logic [39:0] e);
    @(posedge ref_clk);
    fs <= 0; ls <= 0; pv <= 1; pd <= d; nC <= 1; nV <= v; nD <= k; nDat <= e;
  endtask
  task automatic idle(int n);
    repeat (n) begin @(posedge ref_clk); pv <= 0; nC <= 0; end
    @(negedge ref_clk);
  endtask
  task automatic img(int n);
    logic [39:0] d, e;
    @(posedge ref_clk); ls <= 1; pv <= 0; nC <= 0;
    for (int b = 0; b < n; b++) begin
      d = 40'({$random(seed), $random(seed)});
      for (int i = 0; i < 4; i++) e[i*10+:10] = comp(d[i*10+:10], b%16*4+i);
      beat(d, 1, 0, e);
    end
    idle(3);
  endtask
  task automatic frame(int k, int lines, int skip, int depth);
    logic [39:0] d;
    @(posedge ref_clk); fs <= 1; pv <= 0; nC <= 0;
    for (int r = 0; r < lines; r++)
      for (int b = 0; b < 80 * 16; b++) begin
        for (int i = 0; i < 4; i++)
          d[i*10+:10] = r < skip ? 10'h3FF : dv(b % 16 * 4 + i, k);
        beat(d, r >= skip, 1, d);
      end
    idle(4);
    `CHK("darkGen", 1'b0, darkGen)
    if (ctrlV[0] && ctrlV[9:1] != 9'h1FF && (lines-skip)*80 >= 2**depth)
      for (int c = 0; c < 64; c++) ofs[c] = int'(TGT) - int'(dv(c, k));
  endtask
  always @(posedge ref_clk) begin
    pC <= nC; pV <= nV; pD <= nD; pDat <= nDat;
    cycles++;
    if (cycles == 40000) begin nMismatch++; close_out; end
  end
  always @(negedge ref_clk) if (pC) begin
    `CHK("valid", pV, pixOutValid)
    if (pV) `CHK("dark", pD, pixOutDark)
    if (pV) `CHK("pixel", pDat, pixOutData)
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 0;
    chkReg("ctrl", `BLC_IDX_CTRL, 32'h0001);
    chkReg("rows", `BLC_IDX_DARKROW, 32'h0102);
    chkReg("cfg", `BLC_IDX_CALCFG, 32'h0300);
    wb(1, 10'h123, 16'hFFFF);
    wb(1, `BLC_IDX_FAULT, 16'hFFFF);
    chkReg("unmapped", 10'h123, 32'h0);
    chkReg("fault", `BLC_IDX_FAULT, 32'h0);
    for (int t = 0; t < 8; t++) begin
      ctrlV = {5'h00, t == 1 || $random(seed) & 1,
        t < 2 ? 9'h1FF : 9'($random(seed)), 1'b0};
      wb(1, `BLC_IDX_CTRL, ctrlV);
      img(8);
    end
    ctrlV = 16'h0001;
    wb(1, `BLC_IDX_CTRL, ctrlV);
    frame(5, 2, 1, 3);
    `CHK("irq", 1'b0, irq)
    chkReg("status", `BLC_IDX_IRQSTS, 32'h1);
    wb(1, `BLC_IDX_IRQMSK, 16'h0003);
    idle(2);
    `CHK("irq", 1'b1, irq)
    wb(1, `BLC_IDX_IRQSTS, 16'h0003);
    idle(2);
    `CHK("irq", 1'b0, irq)
    img(32);
    ctrlV = 16'h03FF;
    wb(1, `BLC_IDX_CTRL, ctrlV);
    frame(9, 2, 1, 3);
    img(16);
    ctrlV = 16'h0401;
    wb(1, `BLC_IDX_CTRL, ctrlV);
    wb(1, `BLC_IDX_DARKROW, 16'h0203);
    frame(9, 3, 2, 3);
    img(16);
    wb(1, `BLC_IDX_CALCFG, 16'h0700);
    frame(2, 3, 2, 7);
    `CHK("flags", 4'hF, darkCalFaultFlags)
    chkReg("fault", `BLC_IDX_FAULT, 32'hF);
    chkReg("status", `BLC_IDX_IRQSTS, 32'h3);
    img(16);
    close_out;
  end
endmodule
